//--- eeprom_host_pkg.sv
// constants and carrier types for the two-wire memory controller
// assumes one system clock at 250 MHz; the serial clock is divided from it
package eeprom_host_pkg;

  // system clock and serial clock timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCL_PERIOD_NS = 2500;
  // each serial bit is four quarters; rounding down can put the rate slightly above 400 kHz
  localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  // a quarter must outlast the output flop plus the two-flop input synchroniser
  localparam int QUARTER_MIN = 4;

  // device address word layout
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;

  // bit positions inside one serial byte slot
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [1:0] PH_SET = 2'h1;
  localparam logic [1:0] PH_RISE = 2'h2;
  localparam logic [1:0] PH_LAST = 2'h3;

  // page of eight bytes: a write burst is at most one page
  localparam int PAGE_BITS = 3;
  localparam logic [7:0] PAGE_MASK = 8'h07;

  typedef enum logic [2:0] {
    OP_WRITE = 3'h0,
    OP_READ_CUR = 3'h1,
    OP_READ_RAND = 3'h2,
    OP_POLL = 3'h3,
    OP_RECOVER = 3'h4
  } op_t;

  typedef enum logic [1:0] {
    TX_DEVW = 2'h0,
    TX_ADDR = 2'h1,
    TX_DATA = 2'h2,
    TX_DEVR = 2'h3
  } tx_kind_t;

  typedef struct packed {
    op_t op;
    logic [2:0] chip_select_strap;
    logic [7:0] word_addr;
    logic [7:0] count_m1;
  } cmd_t;

  typedef struct packed {
    logic acked;
    logic nacked;
  } result_t;

endpackage : eeprom_host_pkg

//--- eeprom_host_ctrl.sv
// controller that drives a two-wire 256-byte memory through its clock and data pins
// assumes a pull-up on the data line and that no other controller shares the bus
// Notes on behaviour
// - data line changes only while clock is low, except start and stop
// - start is data falling with clock high; one precedes every command
// - stop is data rising with clock high; ends read into standby
// - words are eight bits, msb first; receiver pulls data low on ninth clock
// - recovery: start, nine clocks, start, stop; then ready for new transfer
// - device address word begins with the pattern one, zero, one, zero
// - address word lsb: one starts a read, zero a write
// - byte write: word address, one data byte, each acknowledged, then stop
// - page write: up to seven more bytes after first, then stop
// - polling: start plus address word, acknowledged only after write completes
// - current read: controller answers byte with no acknowledge then stop
// - random read: dummy write of word address, repeated start, current read
// - controller acknowledges to continue reading; no acknowledge plus stop ends
`timescale 1ns/1ns
`default_nettype none

module eeprom_host_ctrl #(
  parameter int QUARTER_CYC = eeprom_host_pkg::QUARTER_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // command request and completion
  input wire logic i_cmd_valid,
  input wire eeprom_host_pkg::cmd_t i_cmd,
  output logic o_cmd_ready,
  output logic o_busy,
  output logic o_done,
  output eeprom_host_pkg::result_t o_result,
  // write data stream
  input wire logic i_wr_valid,
  input wire logic [7:0] i_wr_data,
  output logic o_wr_ready,
  // read data stream
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  // serial pins
  output logic o_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n
);

  if (QUARTER_CYC < eeprom_host_pkg::QUARTER_MIN)
  begin : g_bad_quarter
    $error("QUARTER_CYC too small for the input synchroniser");
  end

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_START = 7'h02,
    S_TX = 7'h04,
    S_RX = 7'h08,
    S_WAIT_WR = 7'h10,
    S_STOP = 7'h20,
    S_CLK9 = 7'h40
  } state_t;

  localparam int TW = $clog2(QUARTER_CYC + 1);
  localparam logic [TW-1:0] QUARTER_LAST = TW'(QUARTER_CYC - 1);

  state_t state_r;
  eeprom_host_pkg::cmd_t cmd_r;
  eeprom_host_pkg::tx_kind_t tx_kind_r;
  logic [TW-1:0] tick_r;
  logic [1:0] phase_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] cnt_r;
  logic second_r;
  logic rec_stage_r;
  logic ack_low_r;
  logic sda_meta_r;
  logic sda_sync_r;
  logic scl_nxt;
  logic sda_rel_nxt;
  logic bit_val;
  logic quarter_end;
  logic prim_end;
  logic sample_pt;
  logic slot_end;
  logic timed;
  logic [7:0] dev_word;

  assign timed = (state_r != S_IDLE) && (state_r != S_WAIT_WR);
  assign quarter_end = timed && (tick_r == QUARTER_LAST);
  assign prim_end = quarter_end && (phase_r == eeprom_host_pkg::PH_LAST);
  assign sample_pt = quarter_end && (phase_r == eeprom_host_pkg::PH_RISE);
  assign slot_end = prim_end && (bit_cnt_r == eeprom_host_pkg::ACK_SLOT);

  assign o_cmd_ready = (state_r == S_IDLE);
  assign o_busy = (state_r != S_IDLE);
  // the byte is only offered once the clock has really gone low, so the stall is visible on the wire
  assign o_wr_ready = (state_r == S_WAIT_WR) && !o_scl;
  // open drain: the pin is only ever pulled low
  assign o_sda = 1'b0;

  // address word: fixed type, straps, direction
  assign dev_word = {eeprom_host_pkg::DEV_TYPE_CODE,
                     cmd_r.chip_select_strap,
                     ((cmd_r.op == eeprom_host_pkg::OP_READ_CUR) || second_r) ?
                     eeprom_host_pkg::RW_READ : eeprom_host_pkg::RW_WRITE};

  // pin input crosses into the system clock through two flops
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
    end
    else
    begin
      sda_meta_r <= i_sda;
      sda_sync_r <= sda_meta_r;
    end
  end

  // quarter-bit timebase
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tick_r <= '0;
      phase_r <= '0;
    end
    else if (!timed)
    begin
      tick_r <= '0;
      phase_r <= '0;
    end
    else if (quarter_end)
    begin
      tick_r <= '0;
      phase_r <= phase_r + 2'h1;
    end
    else
    begin
      tick_r <= tick_r + TW'(1);
    end
  end

  // level released on the data line for the current bit slot
  always_comb
  begin
    bit_val = 1'b1;
    case (state_r)
      S_TX: bit_val = (bit_cnt_r == eeprom_host_pkg::ACK_SLOT) ? 1'b1 : shift_r[7];
      S_RX: bit_val = (bit_cnt_r == eeprom_host_pkg::ACK_SLOT) ? (cnt_r == 8'h00) : 1'b1;
      default: bit_val = 1'b1;
    endcase
  end

  // pin shapes; data moves in the set quarter with the clock low, and in start and stop also in the last quarter with it high
  always_comb
  begin
    scl_nxt = o_scl;
    sda_rel_nxt = o_sda_oe_n;
    case (state_r)
      S_IDLE:
      begin
        scl_nxt = 1'b1;
        sda_rel_nxt = 1'b1;
      end
      S_WAIT_WR:
      begin
        scl_nxt = 1'b0;
      end
      S_START:
      begin
        scl_nxt = phase_r[1];
        if (phase_r == eeprom_host_pkg::PH_SET)
          sda_rel_nxt = 1'b1;
        else if (phase_r == eeprom_host_pkg::PH_LAST)
          sda_rel_nxt = 1'b0;
      end
      S_STOP:
      begin
        scl_nxt = phase_r[1];
        if (phase_r == eeprom_host_pkg::PH_SET)
          sda_rel_nxt = 1'b0;
        else if (phase_r == eeprom_host_pkg::PH_LAST)
          sda_rel_nxt = 1'b1;
      end
      S_TX, S_RX, S_CLK9:
      begin
        scl_nxt = phase_r[1];
        if (phase_r == eeprom_host_pkg::PH_SET)
          sda_rel_nxt = bit_val;
      end
      default:
      begin
        scl_nxt = 1'b1;
        sda_rel_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_scl <= 1'b1;
      o_sda_oe_n <= 1'b1;
    end
    else
    begin
      o_scl <= scl_nxt;
      o_sda_oe_n <= sda_rel_nxt;
    end
  end

  // bit counter within a byte slot; slot nine carries the acknowledge
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      bit_cnt_r <= '0;
    else if (!timed || slot_end)
      bit_cnt_r <= '0;
    else if (prim_end && (state_r != S_START) && (state_r != S_STOP))
      bit_cnt_r <= bit_cnt_r + 4'h1;
  end

  // acknowledge from the device, taken while the clock is high
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      ack_low_r <= 1'b0;
    else if (sample_pt && (state_r == S_TX) && (bit_cnt_r == eeprom_host_pkg::ACK_SLOT))
      ack_low_r <= ~sda_sync_r;
  end

  // read data out, one pulse per received byte
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_rd_valid <= 1'b0;
      o_rd_data <= 8'h00;
    end
    else
    begin
      o_rd_valid <= prim_end && (state_r == S_RX) &&
                    (bit_cnt_r == eeprom_host_pkg::LAST_DATA_BIT);
      if (prim_end && (state_r == S_RX) && (bit_cnt_r == eeprom_host_pkg::LAST_DATA_BIT))
        o_rd_data <= shift_r;
    end
  end

  // command sequencer
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_r <= S_IDLE;
      cmd_r <= '0;
      tx_kind_r <= eeprom_host_pkg::TX_DEVW;
      shift_r <= 8'h00;
      cnt_r <= 8'h00;
      second_r <= 1'b0;
      rec_stage_r <= 1'b0;
      o_done <= 1'b0;
      o_result <= '0;
    end
    else
    begin
      o_done <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (i_cmd_valid)
          begin
            cmd_r <= i_cmd;
            // a write burst never exceeds one page
            cnt_r <= (i_cmd.op == eeprom_host_pkg::OP_WRITE) ?
                     (i_cmd.count_m1 & eeprom_host_pkg::PAGE_MASK) : i_cmd.count_m1;
            second_r <= 1'b0;
            rec_stage_r <= 1'b0;
            o_result <= '0;
            state_r <= S_START;
          end
        end
        S_START:
        begin
          if (prim_end)
          begin
            if (cmd_r.op == eeprom_host_pkg::OP_RECOVER)
            begin
              state_r <= rec_stage_r ? S_STOP : S_CLK9;
              rec_stage_r <= 1'b1;
            end
            else
            begin
              shift_r <= dev_word;
              tx_kind_r <= dev_word[0] ? eeprom_host_pkg::TX_DEVR : eeprom_host_pkg::TX_DEVW;
              state_r <= S_TX;
            end
          end
        end
        S_CLK9:
        begin
          if (slot_end)
            state_r <= S_START;
        end
        S_TX:
        begin
          if (prim_end && (bit_cnt_r < eeprom_host_pkg::ACK_SLOT))
            shift_r <= {shift_r[6:0], 1'b0};
          if (slot_end)
          begin
            if (!ack_low_r)
            begin
              // no answer: busy writing or not present; give up with a stop
              o_result.nacked <= 1'b1;
              state_r <= S_STOP;
            end
            else
            begin
              case (tx_kind_r)
                eeprom_host_pkg::TX_DEVW:
                begin
                  if (cmd_r.op == eeprom_host_pkg::OP_POLL)
                  begin
                    o_result.acked <= 1'b1;
                    state_r <= S_STOP;
                  end
                  else
                  begin
                    shift_r <= cmd_r.word_addr;
                    tx_kind_r <= eeprom_host_pkg::TX_ADDR;
                  end
                end
                eeprom_host_pkg::TX_ADDR:
                begin
                  if (cmd_r.op == eeprom_host_pkg::OP_READ_RAND)
                  begin
                    second_r <= 1'b1;
                    state_r <= S_START;
                  end
                  else
                  begin
                    state_r <= S_WAIT_WR;
                  end
                end
                eeprom_host_pkg::TX_DATA:
                begin
                  if (cnt_r == 8'h00)
                  begin
                    o_result.acked <= 1'b1;
                    state_r <= S_STOP;
                  end
                  else
                  begin
                    cnt_r <= cnt_r - 8'h01;
                    state_r <= S_WAIT_WR;
                  end
                end
                default:
                begin
                  state_r <= S_RX;
                end
              endcase
            end
          end
        end
        S_WAIT_WR:
        begin
          if (i_wr_valid && o_wr_ready)
          begin
            shift_r <= i_wr_data;
            tx_kind_r <= eeprom_host_pkg::TX_DATA;
            state_r <= S_TX;
          end
        end
        S_RX:
        begin
          if (sample_pt && (bit_cnt_r < eeprom_host_pkg::ACK_SLOT))
            shift_r <= {shift_r[6:0], sda_sync_r};
          if (slot_end)
          begin
            if (cnt_r == 8'h00)
            begin
              o_result.acked <= 1'b1;
              state_r <= S_STOP;
            end
            else
            begin
              cnt_r <= cnt_r - 8'h01;
            end
          end
        end
        S_STOP:
        begin
          if (prim_end)
          begin
            o_done <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        default:
        begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule : eeprom_host_ctrl

`default_nettype wire

//--- eeprom_host_sva.sv
// port checks for the two-wire memory controller
// assumes one clock domain; bound into every controller
`timescale 1ns/1ns
`default_nettype none
module eeprom_host_sva #(
  parameter int QUARTER_CYC = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // command side
  input wire logic i_cmd_valid,
  input wire eeprom_host_pkg::cmd_t i_cmd,
  input wire logic o_cmd_ready,
  input wire logic o_busy,
  input wire logic o_done,
  input wire eeprom_host_pkg::result_t o_result,
  // data streams
  input wire logic i_wr_valid,
  input wire logic [7:0] i_wr_data,
  input wire logic o_wr_ready,
  input wire logic o_rd_valid,
  input wire logic [7:0] o_rd_data,
  // serial pins
  input wire logic o_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe_n
);
  // start lands in the first slot, done one quarter after release
  localparam int START_MAX = 4 * QUARTER_CYC + 2;
  localparam int STOP_MAX = QUARTER_CYC + 3;
  logic took;
  assign took = i_cmd_valid && o_cmd_ready;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  a_pins_apart: assert property (
    ($rose(o_scl) || $fell(o_scl)) |-> $stable(o_sda_oe_n)) else $error("data moved on clock edge");
  a_start_first: assert property (
    took |-> ##[1:START_MAX] ($fell(o_sda_oe_n) && o_scl)) else $error("no start after command");
  a_stop_done: assert property (
    ($rose(o_sda_oe_n) && o_scl) |-> ##[1:STOP_MAX] o_done) else $error("stop without done");
  a_idle_free: assert property (
    o_cmd_ready |-> o_scl && o_sda_oe_n) else $error("bus held while idle");
  a_done_pulse: assert property (
    o_done |=> !o_done && o_cmd_ready) else $error("done not a single pulse");
  a_wr_stall: assert property (
    o_wr_ready |-> !o_scl && o_busy) else $error("clock high while awaiting data");
  a_result_clear: assert property (
    took |=> o_result == '0 && o_busy) else $error("result not cleared");
  a_result_hold: assert property (
    $changed(o_result) |-> $past(took) || (($past(o_result) == '0) && o_busy))
    else $error("result moved mid command");
  a_open_drain: assert property (
    o_sda == 1'b0) else $error("data driven high");
  c_acked: cover property (o_done && o_result.acked);
  c_nacked: cover property (o_done && o_result.nacked);
  c_read: cover property (o_rd_valid);
endmodule : eeprom_host_sva
bind eeprom_host_ctrl eeprom_host_sva #(.QUARTER_CYC(QUARTER_CYC)) u_sva (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
  .o_cmd_ready(o_cmd_ready), .o_busy(o_busy), .o_done(o_done), .o_result(o_result),
  .i_wr_valid(i_wr_valid), .i_wr_data(i_wr_data), .o_wr_ready(o_wr_ready),
  .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_scl(o_scl), .i_sda(i_sda),
  .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n));
`default_nettype wire

//--- mem_dev_model.sv
// behavioural two-wire memory device, 256 bytes
// assumes a pull-up on data; runs on serial clock and data edges, with no clock of its own
`timescale 1ns/1ns
`default_nettype none
module mem_dev_model #(
  parameter logic [2:0] STRAP = 3'h5,
  parameter int WR_NS = 8000
) (
  // serial pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_pull
);
  logic [7:0] mem [256];
  logic [7:0] ptr = 8'h00;
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'h00;
  int bitn = 0;
  int st = 0;
  logic rd = 1'b0;
  logic wrote = 1'b0;
  time busy_until = 0;
  initial o_pull = 1'b0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  // a start is ignored while the timed write runs
  always @(negedge i_sda)
    if (i_scl && $time >= busy_until)
    begin
      st = 1;
      bitn = 0;
      rd = 1'b0;
    end
  always @(posedge i_sda)
    if (i_scl)
    begin
      if (wrote) busy_until = $time + WR_NS;
      wrote = 1'b0;
      st = 0;
      rd = 1'b0;
    end
  always @(posedge i_scl)
    if (st != 0)
    begin
      if (bitn < 8 && !rd) sh = {sh[6:0], i_sda};
      if (bitn == 8 && rd && i_sda) st = 0;
      bitn = bitn + 1;
    end
  always @(negedge i_scl)
    if (st != 0)
    begin
      o_pull = 1'b0;
      if (bitn == 9) bitn = 0;
      if (bitn == 8 && !rd)
      begin
        if (st == 3)
        begin
          mem[ptr] = sh;
          ptr = {ptr[7:3], ptr[2:0] + 3'h1};
          wrote = 1'b1;
        end
        if (st == 2) ptr = sh;
        if (st == 2) st = 3;
        if (st == 1) st = (sh[7:1] != {4'ha, STRAP}) ? 0 : (sh[0] ? 4 : 2);
        o_pull = (st != 0);
      end
      else if (bitn == 0 && st == 4)
      begin
        rd = 1'b1;
        tx = mem[ptr];
        ptr = ptr + 8'h01;
        o_pull = !tx[7];
      end
      else if (rd && bitn < 8) o_pull = !tx[7 - bitn];
    end
endmodule : mem_dev_model
`default_nettype wire

//--- tb_top.sv
// self-checking bench: controller against the memory model
// assumes the controller makes the serial clock itself
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [2:0] STRAP = 3'h5;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  eeprom_host_pkg::cmd_t cmd = '0;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic ready, busy, done, rd_valid, scl, sda_o, sda_oe_n, pull, wr_ready, sda;
  logic [7:0] rd_data;
  eeprom_host_pkg::result_t res, got;
  int failures = 0;
  int checks_done = 0;
  int nrd;
  logic [7:0] shadow [256];
  logic [7:0] ptr_exp = 8'h00;
  logic [7:0] wq [8];
  logic [7:0] rq [16];
  always #2 clk = ~clk;
  // open drain with pull-up
  assign sda = !((!sda_oe_n && !sda_o) || pull);
  eeprom_host_ctrl #(.QUARTER_CYC(8)) u_dut (
    .i_clk(clk), .i_arst_n(arst_n), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
    .o_cmd_ready(ready), .o_busy(busy), .o_done(done), .o_result(res),
    .i_wr_valid(wr_valid), .i_wr_data(wr_data), .o_wr_ready(wr_ready),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_scl(scl), .i_sda(sda),
    .o_sda(sda_o), .o_sda_oe_n(sda_oe_n));
  mem_dev_model #(.STRAP(STRAP), .WR_NS(8000)) u_mem (.i_scl(scl), .i_sda(sda), .o_pull(pull));
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [7:0] in_page(input logic [7:0] a, input int i);
    return {a[7:3], a[2:0] + 3'(i)};
  endfunction : in_page
  // inputs move on falling edges only
  task automatic run(input eeprom_host_pkg::op_t op, input logic [2:0] cs,
                     input logic [7:0] wa, input logic [7:0] n);
    int k;
    int w;
    k = 0;
    w = 0;
    nrd = 0;
    @(negedge clk);
    cmd = eeprom_host_pkg::cmd_t'({op, cs, wa, n});
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && k < 20000)
    begin
      if (wr_valid) w++;
      wr_valid = wr_ready;
      wr_data = wq[w[2:0]];
      if (rd_valid) rq[nrd[3:0]] = rd_data;
      nrd = nrd + int'(rd_valid);
      @(negedge clk);
      k++;
    end
    got = res;
    if (k >= 20000) failures++;
  endtask : run
  task automatic wr(input logic [7:0] a, input int n);
    for (int i = 0; i < 8; i++) wq[i] = 8'($urandom);
    run(eeprom_host_pkg::OP_WRITE, STRAP, a, 8'(n - 1));
    chk("write result", {6'h0, got}, 8'h02);
    for (int i = 0; i < n; i++) shadow[in_page(a, i)] = wq[i];
    ptr_exp = in_page(a, n);
    run(eeprom_host_pkg::OP_POLL, STRAP, 8'h00, 8'h00);
    chk("busy poll", {6'h0, got}, 8'h01);
    for (int t = 0; t < 12 && got !== 2'b10; t++) run(eeprom_host_pkg::OP_POLL, STRAP, 8'h00, 8'h00);
    chk("ready poll", {6'h0, got}, 8'h02);
  endtask : wr
  task automatic rdc(input eeprom_host_pkg::op_t op, input logic [7:0] a, input int n);
    logic [7:0] b;
    b = (op == eeprom_host_pkg::OP_READ_CUR) ? ptr_exp : a;
    run(op, STRAP, a, 8'(n - 1));
    chk("read result", {6'h0, got}, 8'h02);
    chk("read count", 8'(nrd), 8'(n));
    for (int i = 0; i < n; i++) chk("read data", rq[i], shadow[8'(b + i)]);
    ptr_exp = 8'(b + n);
  endtask : rdc
  initial
  begin
    logic [7:0] pg;
    void'($urandom(24330));
    for (int i = 0; i < 256; i++) shadow[i] = 8'(i) ^ 8'h5a;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    for (int s = 0; s < 8; s++)
    begin
      run(eeprom_host_pkg::OP_POLL, 3'(s), 8'h00, 8'h00);
      chk("strap poll", {6'h0, got}, (3'(s) == STRAP) ? 8'h02 : 8'h01);
    end
    // full page from offset five wraps inside the page
    pg = {5'($urandom), 3'h5};
    wr(pg, 8);
    rdc(eeprom_host_pkg::OP_READ_CUR, 8'h00, 3);
    rdc(eeprom_host_pkg::OP_READ_RAND, {pg[7:3], 3'h0}, 8);
    pg = 8'($urandom);
    wr(pg, 1);
    rdc(eeprom_host_pkg::OP_READ_RAND, pg, 1);
    rdc(eeprom_host_pkg::OP_READ_RAND, 8'hfd, 6);
    rdc(eeprom_host_pkg::OP_READ_CUR, 8'h00, 1);
    run(eeprom_host_pkg::OP_RECOVER, STRAP, 8'h00, 8'h00);
    chk("recovery", {6'h0, got}, 8'h00);
    rdc(eeprom_host_pkg::OP_READ_CUR, 8'h00, 2);
    run(eeprom_host_pkg::OP_WRITE, ~STRAP, 8'h10, 8'h00);
    chk("foreign write", {6'h0, got}, 8'h01);
    repeat (2) rdc(eeprom_host_pkg::OP_READ_RAND, 8'($urandom), int'($urandom_range(4, 1)));
    print_verdict;
  end
  initial
  begin
    #300000;
    failures++;
    print_verdict;
  end
endmodule : tb_top
`default_nettype wire
